// file: design/ebi_core.sv
// External bus mode latch, pin setup, stretch and register slave
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
`default_nettype none
module ebi_core (
   input  wire logic        CLOCK_IN,
   input  wire logic        RESETN_IN,
   input  wire logic [2:0]  MODE_PINS_IN,
   input  wire ebi_pkg::ext_req_t EXT_REQ_IN,
   input  wire logic [15:0] EXT_RDATA_IN,
   input  wire logic [31:0] AWADDR_IN,
   input  wire logic        AWVALID_IN,
   output logic             AWREADY_OUT,
   input  wire logic [31:0] WDATA_IN,
   input  wire logic [3:0]  WSTRB_IN,
   input  wire logic        WVALID_IN,
   output logic             WREADY_OUT,
   output logic [1:0]       BRESP_OUT,
   output logic             BVALID_OUT,
   input  wire logic        BREADY_IN,
   input  wire logic [31:0] ARADDR_IN,
   input  wire logic        ARVALID_IN,
   output logic             ARREADY_OUT,
   output logic [31:0]      RDATA_OUT,
   output logic [1:0]       RRESP_OUT,
   output logic             RVALID_OUT,
   input  wire logic        RREADY_IN,
   output logic             CPU_HOLD_OUT,
   output logic             EXT_DONE_OUT,
   output logic [15:0]      EXT_RDATA_OUT,
   output logic [15:0]      AD_OUT,
   output logic [15:0]      AD_OE_OUT,
   output logic             E_CLOCK_OUT,
   output logic             E_CLOCK_OE_OUT,
   output logic             CHIP_SELECT_N_OUT,
   output logic             READ_WRITE_OUT,
   output logic             READ_WRITE_OE_OUT,
   output logic             LOW_BYTE_STROBE_N_OUT,
   output logic             LOW_BYTE_STROBE_OE_OUT,
   output logic             QUEUE_STATUS_OE_OUT,
   output logic [7:0]       PORTE_PULL_OUT,
   output logic             MODE_PINS_OE_OUT,
   output logic             IRQ_ENABLE_OUT,
   output logic             NONMASKABLE_INTERRUPT_ENABLE_OUT,
   output logic             BACKGROUND_DEBUG_MODE_ACTIVE_OUT,
   output logic             TIMER_REF_OUT
);
   typedef struct packed {
      logic             was_reset;
      logic [2:0]       mode;
      logic             ivis;
      logic             mode_written;
      ebi_pkg::bus_ctrl_t bc;
      logic             aw_got;
      logic             w_got;
      logic [7:0]       awaddr;
      logic [31:0]      wdata;
      logic             bvalid;
      logic [1:0]       bresp;
      logic             rvalid;
      logic [31:0]      rdata;
      logic [1:0]       rresp;
      ebi_pkg::ext_req_t cyc;
      logic [15:0]      rcap;
      logic             done;
      logic             background_debug_mode;
      logic             tref;
      logic             armed;
   } state_t;
   state_t s, next_s;
   logic e_high;
   logic e_fall;
   logic hold;

   ebi_stretch u_stretch (
      .CLOCK_IN     (CLOCK_IN),
      .RESETN_IN    (RESETN_IN),
      .stretch_in   (s.bc.stretch),
      .stretch_en_in(s.bc.str_en),
      // Count loads only in the cycle's own address phase
      .ext_in       (s.cyc.req && !s.armed),
      .e_high_out   (e_high),
      .e_fall_out   (e_fall),
      .hold_out     (hold)
   );

   logic single_chip;
   logic special;
   logic wr_fire;
   logic rd_fire;
   logic [31:0] rd_val;
   logic [7:0] wa;
   logic [31:0] wd;
   logic [2:0] new_mode;
   logic act;
   always_comb begin
      single_chip = s.mode == ebi_pkg::M_SPECIAL_SC ||
                    s.mode == ebi_pkg::M_NORMAL_SC;
      act = s.cyc.req && s.armed;
      special = !s.mode[2];
      wa = s.aw_got ? s.awaddr : AWADDR_IN[7:0];
      wd = s.w_got ? s.wdata : WDATA_IN;
      wr_fire = (s.aw_got || AWVALID_IN) && (s.w_got || WVALID_IN) &&
                !s.bvalid;
      rd_fire = ARVALID_IN && !s.rvalid;
      new_mode = wd[7:5];
      unique case (ARADDR_IN[7:0])
         ebi_pkg::OFS_BUS_CTRL: rd_val = {25'h0, s.bc.rw_oe, s.bc.lstr_oe,
            s.bc.pipe_oe, s.bc.e_clock_output_dis, s.bc.str_en, s.bc.stretch};
         ebi_pkg::OFS_MODE: rd_val = {24'h0, s.mode, 1'b0, s.ivis, 3'h0};
         ebi_pkg::OFS_STATUS: rd_val = {29'h0, s.background_debug_mode, s.mode_written,
                                        hold};
         default: rd_val = 32'h0;
      endcase
   end

   always_comb begin
      next_s = s;
      next_s.was_reset = 1'b1;
      next_s.done = 1'b0;
      next_s.tref = ~s.tref;  // Free-running, never held
      // Mode latched at first edge after reset release
      if (!s.was_reset) begin
         next_s.mode = MODE_PINS_IN;
         next_s.background_debug_mode = MODE_PINS_IN == ebi_pkg::M_SPECIAL_SC;
         next_s.bc.str_en = MODE_PINS_IN[2];  // User modes
      end
      // AXI4-Lite write
      if (AWVALID_IN && !s.aw_got && !s.bvalid) begin
         next_s.aw_got = 1'b1;
         next_s.awaddr = AWADDR_IN[7:0];
      end
      if (WVALID_IN && !s.w_got && !s.bvalid) begin
         next_s.w_got = 1'b1;
         next_s.wdata = WDATA_IN;
      end
      if (wr_fire) begin
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = ebi_pkg::RESP_OKAY;
         if (wa == ebi_pkg::OFS_BUS_CTRL && WSTRB_IN[0]) begin
            next_s.bc.stretch = wd[1:0];
            next_s.bc.e_clock_output_dis = wd[ebi_pkg::BC_E_CLOCK_OUTPUT_DIS];
            // Protected bit: special modes only
            if (special) next_s.bc.str_en = wd[ebi_pkg::BC_STR_EN];
            next_s.bc.pipe_oe = wd[ebi_pkg::BC_PIPE_OE];
            next_s.bc.lstr_oe = wd[ebi_pkg::BC_LSTR_OE];
            next_s.bc.rw_oe = wd[ebi_pkg::BC_RW_OE];
         end else if (wa == ebi_pkg::OFS_MODE && WSTRB_IN[0]) begin
            // Normal single-chip: one write, expand only
            if (s.mode == ebi_pkg::M_NORMAL_SC && !s.mode_written &&
                (new_mode == ebi_pkg::M_NORMAL_SC ||
                 new_mode == ebi_pkg::M_NORMAL_NARROW ||
                 new_mode == ebi_pkg::M_NORMAL_WIDE)) begin
               next_s.mode = new_mode;
               next_s.ivis = wd[ebi_pkg::MD_IVIS];
               next_s.mode_written = 1'b1;
            end else if (special &&
                         new_mode != ebi_pkg::M_PERIPHERAL) begin
               next_s.mode = new_mode;
               next_s.ivis = wd[ebi_pkg::MD_IVIS];
            end else begin
               next_s.bresp = ebi_pkg::RESP_SLVERR;
            end
         end else if (wa != ebi_pkg::OFS_BUS_CTRL) begin
            next_s.bresp = ebi_pkg::RESP_SLVERR;
         end
      end
      if (s.bvalid && BREADY_IN) next_s.bvalid = 1'b0;
      if (rd_fire) begin
         next_s.rvalid = 1'b1;
         next_s.rdata = rd_val;
         next_s.rresp = (ARADDR_IN[7:0] > ebi_pkg::OFS_STATUS ||
                         ARADDR_IN[1:0] != 2'h0) ?
                        ebi_pkg::RESP_SLVERR : ebi_pkg::RESP_OKAY;
      end
      if (s.rvalid && RREADY_IN) next_s.rvalid = 1'b0;
      // External cycle; no bus in single-chip
      if (!s.cyc.req && EXT_REQ_IN.req && !single_chip)
         next_s.cyc = EXT_REQ_IN;
      // A request may land mid data phase; wait for a full address phase
      if (s.cyc.req && e_fall && !s.armed) next_s.armed = 1'b1;
      if (act && e_fall) begin
         if (!s.cyc.write) next_s.rcap = EXT_RDATA_IN;
         next_s.cyc.req = 1'b0;
         next_s.armed = 1'b0;
         next_s.done = 1'b1;
      end
      // Single-chip forces bus enables low
      if (single_chip) begin
         next_s.bc.pipe_oe = 1'b0;
         next_s.bc.lstr_oe = 1'b0;
         next_s.bc.rw_oe = 1'b0;
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (!RESETN_IN) begin
         s <= '0;
         s.bc.str_en <= 1'b1;
         s.bc.stretch <= ebi_pkg::STRETCH_RST;
      end else begin
         s <= next_s;
      end
   end

   // Registered pins; all driven from flops
   always_ff @(posedge CLOCK_IN) begin
      if (!RESETN_IN) begin
         AD_OUT <= 16'h0;
         AD_OE_OUT <= 16'h0;
         CHIP_SELECT_N_OUT <= 1'b1;
         READ_WRITE_OUT <= 1'b1;
         READ_WRITE_OE_OUT <= 1'b0;
         LOW_BYTE_STROBE_N_OUT <= 1'b1;
         LOW_BYTE_STROBE_OE_OUT <= 1'b0;
         QUEUE_STATUS_OE_OUT <= 1'b0;
         PORTE_PULL_OUT <= 8'h0;
         MODE_PINS_OE_OUT <= 1'b0;  // Mode pins float in reset
         IRQ_ENABLE_OUT <= 1'b0;  // Inhibited at reset
         NONMASKABLE_INTERRUPT_ENABLE_OUT <= 1'b0;
         E_CLOCK_OUT <= 1'b0;
         E_CLOCK_OE_OUT <= 1'b0;
         CPU_HOLD_OUT <= 1'b0;
         EXT_DONE_OUT <= 1'b0;
         EXT_RDATA_OUT <= 16'h0;
         BACKGROUND_DEBUG_MODE_ACTIVE_OUT <= 1'b0;
         TIMER_REF_OUT <= 1'b0;
      end else begin
         // Address only outside E high; data held through stretch only while str_en is set
         AD_OUT <= (act && e_high) ? s.cyc.wdata : s.cyc.addr;
         AD_OE_OUT <= {16{s.cyc.req && (!(act && e_high) || s.cyc.write)}};
         CHIP_SELECT_N_OUT <= !(act && e_high);
         READ_WRITE_OUT <= !(s.cyc.req && s.cyc.write);
         READ_WRITE_OE_OUT <= s.bc.rw_oe && !single_chip;
         LOW_BYTE_STROBE_N_OUT <= !s.cyc.req || s.cyc.addr[0];
         LOW_BYTE_STROBE_OE_OUT <= s.bc.lstr_oe && !single_chip &&
                                   s.mode != ebi_pkg::M_NORMAL_NARROW;
         QUEUE_STATUS_OE_OUT <= s.bc.pipe_oe && !single_chip;
         PORTE_PULL_OUT <= 8'hef;  // Port E pulled, pin 4 E clock
         MODE_PINS_OE_OUT <= 1'b0;
         IRQ_ENABLE_OUT <= 1'b0;
         NONMASKABLE_INTERRUPT_ENABLE_OUT <= 1'b0;
         // Same register depth as select and bus, so edges line up
         E_CLOCK_OUT <= !s.bc.e_clock_output_dis && e_high;
         E_CLOCK_OE_OUT <= !s.bc.e_clock_output_dis;
         CPU_HOLD_OUT <= hold;
         EXT_DONE_OUT <= s.done;
         EXT_RDATA_OUT <= s.rcap;
         BACKGROUND_DEBUG_MODE_ACTIVE_OUT <= s.background_debug_mode;
         TIMER_REF_OUT <= s.tref;
      end
   end

   assign AWREADY_OUT = !s.aw_got && !s.bvalid;
   assign WREADY_OUT = !s.w_got && !s.bvalid;
   assign BVALID_OUT = s.bvalid;
   assign BRESP_OUT = s.bresp;
   assign ARREADY_OUT = !s.rvalid;
   assign RVALID_OUT = s.rvalid;
   assign RDATA_OUT = s.rdata;
   assign RRESP_OUT = s.rresp;

   property p_latch;
      @(posedge CLOCK_IN) disable iff (!RESETN_IN)
      !s.was_reset |=> s.mode == $past(MODE_PINS_IN);
   endproperty
   a_latch: assert property (p_latch)
      else $error("mode not latched");
   property p_sc_oe;
      @(posedge CLOCK_IN) disable iff (!RESETN_IN)
      s.was_reset && single_chip |=> !READ_WRITE_OE_OUT &&
         !QUEUE_STATUS_OE_OUT;
   endproperty
   a_sc_oe: assert property (p_sc_oe)
      else $error("single chip enable active");
   property p_once;
      @(posedge CLOCK_IN) disable iff (!RESETN_IN)
      s.mode_written |=> $stable(s.mode) || special;
   endproperty
   a_once: assert property (p_once)
      else $error("mode written twice");
   property p_tref;
      @(posedge CLOCK_IN) disable iff (!RESETN_IN)
      s.was_reset |=> s.tref != $past(s.tref);
   endproperty
   a_tref: assert property (p_tref)
      else $error("timer ref stalled");
   property p_cs;
      @(posedge CLOCK_IN) disable iff (!RESETN_IN)
      (act && e_high) |=> !CHIP_SELECT_N_OUT;
   endproperty
   a_cs: assert property (p_cs)
      else $error("chip select dropped");
   sequence s_addr_ph;
      s.cyc.req && !s.armed && e_fall;
   endsequence
   property p_addr_out;
      @(posedge CLOCK_IN) disable iff (!RESETN_IN)
      s_addr_ph |=> AD_OUT == s.cyc.addr && CHIP_SELECT_N_OUT;
   endproperty
   a_addr_out: assert property (p_addr_out)
      else $error("address phase not on bus");
   property p_wr_data;
      @(posedge CLOCK_IN) disable iff (!RESETN_IN)
      (act && e_high && s.cyc.write) |=> AD_OUT == s.cyc.wdata &&
         AD_OE_OUT == 16'hffff;
   endproperty
   a_wr_data: assert property (p_wr_data)
      else $error("write data dropped in stretch");
endmodule : ebi_core
`default_nettype wire

// file: design/ebi_pkg.sv
// Constants and types for the external bus mode and stretch block
`default_nettype none
package ebi_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   // Register byte addresses
   localparam logic [7:0] OFS_BUS_CTRL = 8'h00;
   localparam logic [7:0] OFS_MODE     = 8'h04;
   localparam logic [7:0] OFS_PORTE    = 8'h08;
   localparam logic [7:0] OFS_STATUS   = 8'h0c;
   // Field positions, bus control register
   localparam int BC_STRETCH_LO = 0;
   localparam int BC_STR_EN     = 2;
   localparam int BC_E_CLOCK_OUTPUT_DIS   = 3;
   localparam int BC_PIPE_OE    = 4;
   localparam int BC_LSTR_OE    = 5;
   localparam int BC_RW_OE      = 6;
   // Field positions, mode register
   localparam int MD_IVIS = 3;
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam logic [1:0] STRETCH_RST = 2'h3;
   localparam int E_HALF = 2;
   typedef enum logic [2:0] {
      M_SPECIAL_SC   = 3'h0,
      M_EMU_NARROW   = 3'h1,
      M_SPECIAL_TEST = 3'h2,
      M_EMU_WIDE     = 3'h3,
      M_NORMAL_SC    = 3'h4,
      M_NORMAL_NARROW = 3'h5,
      M_PERIPHERAL   = 3'h6,
      M_NORMAL_WIDE  = 3'h7
   } mode_t;
   typedef struct packed {
      logic [1:0] stretch;
      logic       str_en;
      logic       e_clock_output_dis;
      logic       pipe_oe;
      logic       lstr_oe;
      logic       rw_oe;
   } bus_ctrl_t;
   typedef struct packed {
      logic       req;
      logic       write;
      logic [15:0] addr;
      logic [15:0] wdata;
   } ext_req_t;
endpackage : ebi_pkg
`default_nettype wire

// file: design/ebi_stretch.sv
// E clock phase sequencer with programmable stretch
`default_nettype none
module ebi_stretch (
   input  wire logic       CLOCK_IN,
   input  wire logic       RESETN_IN,
   input  wire logic [1:0] stretch_in,
   input  wire logic       stretch_en_in,
   input  wire logic       ext_in,
   output logic            e_high_out,
   output logic            e_fall_out,
   output logic            hold_out
);
   typedef enum logic [1:0] {S_ADDR, S_DATA, S_STR} ph_t;
   typedef struct packed {
      ph_t        ph;
      logic [1:0] cnt;
      logic       e;
      logic       fall;
      logic       hold;
   } st_t;
   st_t s, next_s;
   always_comb begin
      next_s = s;
      next_s.fall = 1'b0;
      unique case (s.ph)
         S_ADDR: begin  // Address phase never lengthened
            next_s.ph = S_DATA;
            next_s.e = 1'b1;
            next_s.cnt = ext_in ? stretch_in : 2'h0;
            next_s.hold = ext_in && stretch_in != 2'h0;
         end
         S_DATA, S_STR: begin
            if (s.cnt != 2'h0) begin
               next_s.cnt = s.cnt - 2'h1;
               next_s.ph = S_STR;
               next_s.hold = s.cnt != 2'h1;
               // E held low through the stretch when stretch disabled
               if (!stretch_en_in) next_s.e = 1'b0;
            end else begin
               next_s.ph = S_ADDR;
               next_s.hold = 1'b0;
               next_s.fall = 1'b1;  // Read sample point
               next_s.e = 1'b0;
            end
         end
      endcase
   end
   always_ff @(posedge CLOCK_IN) begin
      if (!RESETN_IN) s <= '{ph: S_ADDR, cnt: 2'h0, e: 1'b0,
                              fall: 1'b0, hold: 1'b0};
      else s <= next_s;
   end
   assign e_high_out = s.e;
   assign e_fall_out = s.fall;
   assign hold_out = s.hold;

   property p_hold_len;
      @(posedge CLOCK_IN) disable iff (!RESETN_IN)
      (s.ph == S_ADDR && ext_in && stretch_in == 2'h2)
         |=> hold_out ##1 hold_out ##1 !hold_out;
   endproperty
   a_hold_len: assert property (p_hold_len)
      else $error("hold length wrong");
   property p_no_str;
      @(posedge CLOCK_IN) disable iff (!RESETN_IN)
      (s.ph == S_ADDR && !ext_in) |=> !hold_out ##1 e_fall_out;
   endproperty
   a_no_str: assert property (p_no_str)
      else $error("unstretched cycle wrong");
   property p_addr_one;
      @(posedge CLOCK_IN) disable iff (!RESETN_IN)
      (s.ph == S_ADDR) |=> s.ph != S_ADDR;
   endproperty
   a_addr_one: assert property (p_addr_one)
      else $error("address phase stretched");
endmodule : ebi_stretch
`default_nettype wire

// file: dv/ext_mem_model.sv
// External memory responder on the multiplexed bus
`default_nettype none
module ext_mem_model (
   input  wire logic        clk_in,
   input  wire logic        e_in,
   input  wire logic        cs_n_in,
   input  wire logic        rw_in,
   input  wire logic [15:0] ad_in,
   output logic      [15:0] rdata_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [16];
   logic [15:0] addr;
   logic [15:0] idle = 16'h5a5a;
   // Address only valid outside E high
   always_ff @(posedge clk_in) begin
      idle <= ~idle;
      if (!e_in)
         addr <= ad_in;
      else if (!cs_n_in && !rw_in)
         mem[addr[3:0]] <= ad_in;
   end
   // Released bus shows a changing pattern, never stale data
   always_comb begin
      if (e_in && !cs_n_in && rw_in)
         rdata_out = mem[addr[3:0]];
      else
         rdata_out = idle;
   end
endmodule : ext_mem_model
`default_nettype wire

// file: dv/tb_ebi_core.sv
// Self-checking bench for the external bus mode and stretch block
`default_nettype none
module tb_ebi_core;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, awv, wv, bry, arv, rry;
   logic [2:0] mpins;
   logic [31:0] awa, wd, ara;
   ebi_pkg::ext_req_t req;
   wire logic [15:0] rdat, xrd, ad;
   wire logic [31:0] rd32;
   wire logic [1:0] brsp, rrsp;
   wire logic [7:0] pull;
   wire logic awr, wr, bv, arr, rv, hold, done, e_clock_output, csn, rw, qoe;
   wire logic rwoe, lsoe, moe, irqe, nmie, background_debug_mode, tref, eoe;
   int n_mismatch = 0;
   int checked = 0;
   int cyc = 0;
   int run = 0;
   logic e_q, t_q;
   logic [1:0] cs_q;

   ebi_core u_ebi_core (.CLOCK_IN(clk), .RESETN_IN(rst_n),
      .MODE_PINS_IN(mpins), .EXT_REQ_IN(req), .EXT_RDATA_IN(rdat),
      .AWADDR_IN(awa), .AWVALID_IN(awv), .AWREADY_OUT(awr),
      .WDATA_IN(wd), .WSTRB_IN(4'hf), .WVALID_IN(wv), .WREADY_OUT(wr),
      .BRESP_OUT(brsp), .BVALID_OUT(bv), .BREADY_IN(bry),
      .ARADDR_IN(ara), .ARVALID_IN(arv), .ARREADY_OUT(arr),
      .RDATA_OUT(rd32), .RRESP_OUT(rrsp), .RVALID_OUT(rv),
      .RREADY_IN(rry), .CPU_HOLD_OUT(hold), .EXT_DONE_OUT(done),
      .EXT_RDATA_OUT(xrd), .AD_OUT(ad), .AD_OE_OUT(),
      .E_CLOCK_OUT(e_clock_output), .E_CLOCK_OE_OUT(eoe), .CHIP_SELECT_N_OUT(csn),
      .READ_WRITE_OUT(rw), .READ_WRITE_OE_OUT(rwoe),
      .LOW_BYTE_STROBE_N_OUT(), .LOW_BYTE_STROBE_OE_OUT(lsoe),
      .QUEUE_STATUS_OE_OUT(qoe), .PORTE_PULL_OUT(pull),
      .MODE_PINS_OE_OUT(moe), .IRQ_ENABLE_OUT(irqe),
      .NONMASKABLE_INTERRUPT_ENABLE_OUT(nmie),
      .BACKGROUND_DEBUG_MODE_ACTIVE_OUT(background_debug_mode), .TIMER_REF_OUT(tref));

   ext_mem_model u_ext_mem_model (.clk_in(clk), .e_in(e_clock_output),
      .cs_n_in(csn), .rw_in(rw), .ad_in(ad), .rdata_out(rdat));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic results;
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : results

   task automatic cmp_word(input string nm, input logic [31:0] e,
                           input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp_word

   task automatic cmp_bit(input string nm, input logic e, input logic g);
      cmp_word(nm, {31'h0, e}, {31'h0, g});
   endtask : cmp_bit

   task automatic axi_write(input logic [31:0] a, input logic [31:0] d,
                            input logic [1:0] er);
      logic ta, tw;
      ta = 1'b0;
      tw = 1'b0;
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      while (!(ta && tw)) begin
         @(posedge clk);
         if (!ta && awr === 1'b1) begin
            ta = 1'b1;
            awv <= 1'b0;
         end
         if (!tw && wr === 1'b1) begin
            tw = 1'b1;
            wv <= 1'b0;
         end
      end
      while (bv !== 1'b1) @(posedge clk);
      cmp_word("bresp", {30'h0, er}, {30'h0, brsp});
      bry <= 1'b0;
   endtask : axi_write

   task automatic chk_reg(input logic [31:0] a, input logic [31:0] m,
                          input logic [31:0] e, input logic [1:0] er);
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      do @(posedge clk); while (arr !== 1'b1);
      arv <= 1'b0;
      while (rv !== 1'b1) @(posedge clk);
      cmp_word("rresp", {30'h0, er}, {30'h0, rrsp});
      cmp_word("reg", e, rd32 & m);
      rry <= 1'b0;
   endtask : chk_reg

   task automatic ext_cycle(input logic w, input logic [15:0] a,
                            input logic [15:0] d, input int s);
      int n, h;
      n = 0;
      h = 0;
      // Issue in step with the E clock so the count is exact
      do @(posedge clk); while (e_clock_output !== 1'b1);
      req <= '{1'b1, w, a, d};
      @(posedge clk);
      req.req <= 1'b0;
      do begin
         @(posedge clk);
         #1;
         n++;
         if (hold === 1'b1)
            h++;
      end while (done !== 1'b1 && n < 40);
      cmp_word("latency", 32'(4 + s), 32'(n));
      cmp_word("hold", 32'(s), 32'(h));
      if (!w)
         cmp_word("rdata", {16'h0, d}, {16'h0, xrd});
   endtask : ext_cycle

   task automatic do_reset(input logic [2:0] m);
      @(posedge clk);
      rst_n <= 1'b0;
      mpins <= m;
      repeat (5) @(posedge clk);
      cmp_bit("mode_oe", 1'b0, moe);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      mpins <= ~m;
   endtask : do_reset

   // Stretch must never slow the timer reference
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         results();
      end
      run = rst_n ? run + 1 : 0;
      if (run > 3)
         cmp_bit("timer_ref", ~t_q, tref);
      if (e_q === 1'b1 && e_clock_output === 1'b1)
         cmp_word("cs_rw", {30'h0, cs_q}, {30'h0, csn, rw});
      t_q = tref;
      e_q = e_clock_output;
      cs_q = {csn, rw};
   end

   initial begin
      int k;
      logic [15:0] a0, d0;
      logic pe;
      rst_n = 1'b0;
      mpins = 3'h0;
      req = '0;
      {awv, wv, bry, arv, rry} = '0;
      {awa, wd, ara} = '0;
      do_reset(3'h0);
      cmp_bit("debug", 1'b1, background_debug_mode);
      cmp_bit("e_clock_output_oe", 1'b1, eoe);
      cmp_word("int_en", 32'h0, {30'h0, irqe, nmie});
      cmp_word("pulls", 32'h3, {30'h0, pull[1:0]});
      chk_reg(ebi_pkg::OFS_MODE, 32'he0, 32'h0, 2'b00);
      chk_reg(ebi_pkg::OFS_BUS_CTRL, 32'h77, 32'h03, 2'b00);
      axi_write(ebi_pkg::OFS_BUS_CTRL, 32'h74, 2'b00);
      chk_reg(ebi_pkg::OFS_BUS_CTRL, 32'h04, 32'h04, 2'b00);
      cmp_word("bus_oe", 32'h0, {29'h0, qoe, rwoe, lsoe});
      axi_write(ebi_pkg::OFS_MODE, 32'hc0, 2'b10);
      chk_reg(ebi_pkg::OFS_MODE, 32'he0, 32'h0, 2'b00);
      chk_reg(32'h10, 32'h0, 32'h0, 2'b10);
      k = 0;
      pe = e_clock_output;
      repeat (16) begin
         @(posedge clk);
         if (e_clock_output !== pe)
            k++;
         pe = e_clock_output;
      end
      cmp_bit("e_clock_output_runs", 1'b1, k > 0);
      do_reset(3'h4);
      cmp_bit("debug", 1'b0, background_debug_mode);
      chk_reg(ebi_pkg::OFS_BUS_CTRL, 32'h77, 32'h07, 2'b00);
      axi_write(ebi_pkg::OFS_BUS_CTRL, 32'h0, 2'b00);
      chk_reg(ebi_pkg::OFS_BUS_CTRL, 32'h04, 32'h04, 2'b00);
      // No external bus yet, so a request must go unanswered
      @(posedge clk);
      req <= '{1'b1, 1'b0, 16'h0100, 16'h0};
      k = 0;
      repeat (12) begin
         @(posedge clk);
         if (done === 1'b1)
            k++;
      end
      req.req <= 1'b0;
      cmp_word("sc_done", 32'h0, 32'(k));
      axi_write(ebi_pkg::OFS_MODE, 32'he0, 2'b00);
      axi_write(ebi_pkg::OFS_MODE, 32'ha0, 2'b10);
      chk_reg(ebi_pkg::OFS_MODE, 32'he0, 32'he0, 2'b00);
      for (int s = 0; s < 4; s++) begin
         axi_write(ebi_pkg::OFS_BUS_CTRL, 32'h40 | s, 2'b00);
         a0 = 16'h0100 + 16'(2 * s);
         d0 = 16'hc3a0 + 16'(s);
         ext_cycle(1'b1, a0, d0, s);
         ext_cycle(1'b1, a0 + 16'h0021, ~d0, s);
         ext_cycle(1'b0, a0, d0, s);
      end
      results();
   end
endmodule : tb_ebi_core
`default_nettype wire
